// [rtl/dmhbi_host_bus.sv]
// host bus slave: decode, buffer control, ready pacing, palette strobes
`timescale 1ns/1ps
`default_nettype none
module dmhbi_host_bus (
    input wire logic clk,
    input wire logic reset,
    input wire logic video_clk,
    input wire logic [7:0] config_register,
    input wire logic [7:0] extended_control_1,
    input wire logic [dmhbi_pkg::ADDR_W-1:0] host_addr,
    input wire logic memory_space_select,
    input wire logic high_byte_enable_n,
    input wire logic memory_read_strobe_n,
    input wire logic memory_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic command_n,
    input wire logic status_write_n,
    input wire logic status_read_n,
    input wire logic mem_not_io,
    input wire logic io_enable_card_setup_n,
    input wire logic memory_ack,
    output logic memory_request,
    output logic rom_select_n,
    output logic palette_read_strobe_n,
    output logic palette_write_strobe_n,
    output logic select_feedback_n,
    output logic wide_transfer_response_n,
    output logic addr_buffer_enable_n,
    output logic data_buffer_enable_n,
    output logic buffer_direction,
    output logic ready_out,
    output logic ready_oe
);
    import dmhbi_pkg::*;

    typedef struct packed {
        dmhbi_state_t st;
        logic [1:0] cnt;
        logic rd;
        logic wr;
        logic io;
        logic chan;
        logic vhit;
        logic mhit;
        logic cd_low;
        logic [19:0] a;
        logic pend_rd;
        logic pend_wr;
        logic pend_io;
        logic [19:0] pend_a;
        logic rom_n;
        logic prd_n;
        logic pwr;
        logic sfb_n;
        logic wide_n;
        logic abuf_n;
        logic dbuf_n;
        logic dir;
        logic rdy;
        logic rdy_oe;
        logic mreq;
    } dmhbi_core_t;

    dmhbi_core_t q, d;
    dmhbi_pins_t p;

    dmhbi_sync_if #(.W($bits(dmhbi_pins_t))) pin_if ();
    dmhbi_sync_if #(.W(1)) pal_if ();

    // every host pin is asynchronous to the memory clock
    assign pin_if.raw = {host_addr, memory_space_select,
        high_byte_enable_n, memory_read_strobe_n, memory_write_strobe_n,
        io_read_strobe_n, io_write_strobe_n, command_n, status_write_n,
        status_read_n, mem_not_io, io_enable_card_setup_n};
    assign p = dmhbi_pins_t'(pin_if.synced);

    dmhbi_sync #(.STAGES(2)) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .port(pin_if.syncer)
    );

    // request is held through data-off, longer than a pixel period,
    // so a plain two stage crossing cannot miss it; sent active low
    assign pal_if.raw = !q.pwr;

    dmhbi_sync #(.STAGES(2)) u_pal_sync (
        .clk(video_clk),
        .reset(reset),
        .port(pal_if.syncer)
    );

    function automatic logic in20(input logic [19:0] a,
                                  input logic [19:0] lo,
                                  input logic [19:0] hi);
        in20 = (a >= lo) && (a <= hi);
    endfunction : in20

    function automatic logic in16(input logic [19:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
        in16 = (a[15:0] >= lo) && (a[15:0] <= hi);
    endfunction : in16

    logic chan_mode;
    logic rom_en;
    logic stat_on;
    logic isa_rd;
    logic isa_wr;
    logic isa_io;
    logic ch_rd;
    logic ch_wr;
    logic ch_io;
    logic [19:0] ch_a;
    logic start;
    logic s_rd;
    logic s_wr;
    logic s_io;
    logic [19:0] s_a;
    logic cmd_end;
    logic mem_dec;
    logic io_dec;
    logic cd_low;
    logic go;
    logic [1:0] dly;

    always_comb begin
        chan_mode = config_register[CFG_CHAN_BIT];
        rom_en = extended_control_1[EXT1_ROM_EN_BIT];
        stat_on = !p.s0_n || !p.s1_n;
        isa_rd = !p.mrd_n || !p.ior_n;
        isa_wr = !p.mwr_n || !p.iow_n;
        isa_io = !p.ior_n || !p.iow_n;
        // status may vanish right after the command edge, so the
        // captured copy stands in once it is gone
        ch_rd = stat_on ? !p.s1_n : q.pend_rd;
        ch_wr = stat_on ? !p.s0_n : q.pend_wr;
        ch_io = stat_on ? !p.mem_io : q.pend_io;
        ch_a = stat_on ? p.addr : q.pend_a;
        if (chan_mode) begin
            start = !p.cmd_n && (ch_rd || ch_wr);
            s_rd = ch_rd;
            s_wr = ch_wr;
            s_io = ch_io;
            s_a = ch_a;
        end else begin
            start = isa_rd || isa_wr;
            s_rd = isa_rd;
            s_wr = isa_wr;
            s_io = isa_io;
            s_a = p.addr;
        end
        cmd_end = q.chan ? p.cmd_n : !(isa_rd || isa_wr);
        // address phase decode, ahead of any command
        mem_dec = p.mem_space && (chan_mode ? p.mem_io : 1'b1)
            && (in20(p.addr, VMEM_LO, VMEM_HI)
                || in20(p.addr, ROM_LO, ROM_HI));
        io_dec = chan_mode && !p.mem_io
            && (in16(p.addr, VGA_IO_LO, VGA_IO_HI)
                || p.addr[15:0] == SETUP_PORT
                || p.addr[15:0] == ROM_PAGE_PORT);
        // setup pin means nothing outside port 102
        cd_low = chan_mode && !p.mem_io
            && p.addr[15:0] == SETUP_PORT && !p.ion_n;
        if (q.chan && q.io) begin
            dly = q.rd ? IO_RD_DLY : IO_WR_DLY;
        end else begin
            dly = 2'h0;
        end
        go = q.cnt >= dly;
    end

    always_comb begin
        d = q;
        d.sfb_n = !(chan_mode && (mem_dec || io_dec)) || cd_low
            || q.cd_low;
        d.wide_n = !(mem_dec && !p.bhe_n);
        if (q.st == ST_IDLE && stat_on) begin
            d.pend_rd = !p.s1_n;
            d.pend_wr = !p.s0_n;
            d.pend_io = !p.mem_io;
            d.pend_a = p.addr;
        end
        case (q.st)
            ST_IDLE: begin
                d.abuf_n = 1'b0;
                d.dbuf_n = 1'b1;
                d.dir = 1'b0;
                d.rdy_oe = 1'b0;
                d.rdy = 1'b0;
                d.rom_n = 1'b1;
                d.prd_n = 1'b1;
                d.pwr = 1'b0;
                d.mreq = 1'b0;
                d.cnt = 2'h0;
                d.cd_low = 1'b0;
                if (start) begin
                    d.st = ST_ADDR_OFF;
                    d.rd = s_rd;
                    d.wr = s_wr && !s_rd;
                    d.io = s_io;
                    d.chan = chan_mode;
                    d.a = s_a;
                    d.cd_low = cd_low;
                    d.vhit = !s_io && p.mem_space
                        && in20(s_a, VMEM_LO, VMEM_HI);
                    d.mhit = !s_io && p.mem_space
                        && (in20(s_a, VMEM_LO, VMEM_HI)
                            || in20(s_a, ROM_LO, ROM_HI));
                    d.abuf_n = 1'b1;
                    d.dir = s_rd;
                    d.pend_rd = 1'b0;
                    d.pend_wr = 1'b0;
                end
            end
            ST_ADDR_OFF: begin
                d.st = ST_ACTIVE;
                d.dbuf_n = 1'b0;
                // ready is pulled low early on our memory cycles
                d.rdy_oe = q.mhit;
                d.rdy = 1'b0;
                d.mreq = q.vhit;
            end
            ST_ACTIVE: begin
                if (q.cnt != 2'h3) begin
                    d.cnt = q.cnt + 2'h1;
                end
                d.prd_n = !(go && q.io && q.rd
                    && in16(q.a, PAL_LO, PAL_HI)
                    && q.a[15:0] != PAL_NORD);
                d.pwr = go && q.io && q.wr
                    && in16(q.a, PAL_LO, PAL_HI);
                d.rom_n = !((rom_en && !q.io && q.rd
                    && in20(q.a, ROM_LO, ROM_HI)
                    && !in20(q.a, ROM_XLO, ROM_XHI))
                    || (!q.chan && q.io && q.wr
                    && q.a[15:0] == ROM_PAGE_PORT));
                // contention ends when the arbiter answers
                if (q.mreq && memory_ack) begin
                    d.mreq = 1'b0;
                    d.rdy = 1'b1;
                end else if (q.mhit && !q.vhit) begin
                    d.rdy = 1'b1;
                end
                if (cmd_end) begin
                    d.st = ST_DATA_OFF;
                    d.dbuf_n = 1'b1;
                    d.prd_n = 1'b1;
                    // write request stays up until idle for the pixel side
                    d.rom_n = 1'b1;
                    d.mreq = 1'b0;
                    d.rdy = 1'b0;
                    d.rdy_oe = 1'b0;
                end
            end
            ST_DATA_OFF: begin
                d.st = ST_IDLE;
                d.abuf_n = 1'b0;
                d.dir = 1'b0;
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.rom_n <= 1'b1;
            q.prd_n <= 1'b1;
            q.sfb_n <= 1'b1;
            q.wide_n <= 1'b1;
            q.dbuf_n <= 1'b1;
            q.dir <= DIR_RST;
        end else begin
            q <= d;
        end
    end

    assign memory_request = q.mreq;
    assign rom_select_n = q.rom_n;
    assign palette_read_strobe_n = q.prd_n;
    assign palette_write_strobe_n = pal_if.synced;
    assign select_feedback_n = q.sfb_n;
    assign wide_transfer_response_n = q.wide_n;
    assign addr_buffer_enable_n = q.abuf_n;
    assign data_buffer_enable_n = q.dbuf_n;
    assign buffer_direction = q.dir;
    assign ready_out = q.rdy;
    assign ready_oe = q.rdy_oe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_rom_excl_gap: assert property (
        !rom_select_n && !q.io |->
            !in20(q.a, ROM_XLO, ROM_XHI) && q.rd
            && in20(q.a, ROM_LO, ROM_HI))
        else $error("rom select inside excluded range");

    a_prd_port_ok: assert property (
        !palette_read_strobe_n |-> q.io && q.rd
            && in16(q.a, PAL_LO, PAL_HI) && q.a[15:0] != PAL_NORD)
        else $error("palette read on wrong port");

    a_pwr_port_ok: assert property (
        q.pwr |-> q.io && q.wr && in16(q.a, PAL_LO, PAL_HI))
        else $error("palette write on wrong port");

    a_setup_blocks_sfb: assert property (
        cd_low |=> select_feedback_n)
        else $error("select feedback with card setup low");

    a_chan_rd_delay: assert property (
        $fell(palette_read_strobe_n) && q.chan |->
            $past(q.st == ST_ACTIVE, 3))
        else $error("channel read strobe too early");

    a_chan_wr_delay: assert property (
        $rose(q.pwr) && q.chan |->
            $past(q.st == ST_ACTIVE, 4))
        else $error("channel write strobe too early");

    a_wide_cause: assert property (
        !wide_transfer_response_n |-> $past(mem_dec && !p.bhe_n))
        else $error("wide response without wide memory hit");

    a_ready_low_early: assert property (
        q.st == ST_ADDR_OFF && q.mhit |=> ready_oe && !ready_out)
        else $error("ready not pulled low at start");

    a_ready_release: assert property (
        q.st == ST_DATA_OFF |-> !ready_oe ##1 !ready_oe)
        else $error("ready still driven after command");

    a_abuf_first: assert property (
        $fell(data_buffer_enable_n) |->
            addr_buffer_enable_n && $past(addr_buffer_enable_n))
        else $error("data buffer on before address buffer off");

    a_dbuf_first: assert property (
        $fell(addr_buffer_enable_n) |->
            data_buffer_enable_n && $past(data_buffer_enable_n))
        else $error("address buffer on before data buffer off");

    a_dir_leads_rd: assert property (
        !palette_read_strobe_n |->
            buffer_direction && $past(buffer_direction))
        else $error("direction not ahead of read strobe");

    a_dir_reset_low: assert property (
        disable iff (1'b0) reset |=> !buffer_direction)
        else $error("direction not low after reset");
endmodule : dmhbi_host_bus
`default_nettype wire

// [rtl/dmhbi_pkg.sv]
// constants and types of the dual mode host bus interface
// What this block does
// - rom select for rom window reads and isa mode port 46E8 writes
// - palette read strobe 3C6-3C9, never 3C7
// - palette write strobe only ports 3C6-3C9
// - card setup honoured only at port 102
// - card setup low keeps select feedback off
// - channel io read starts two periods late
// - channel io write runs three periods late
// - wide response only for 16-bit memory hits
// - video memory or rom window access drives ready low, then high
// - ready released after command ends
// - configuration bit 2 selects bus mode
// - address buffer off before data buffer on
// - data buffer off before address buffer on
// - direction leads read strobe, trails its end
// - palette read strobe on memory clock
// - palette write strobe on pixel clock
// - channel select feedback follows address decode
// - rom decode enable bit, port 46E8 strobe
// - direction low after reset
package dmhbi_pkg;
    localparam int ADDR_W = 20;
    localparam logic [19:0] VMEM_LO = 20'hA0000;
    localparam logic [19:0] VMEM_HI = 20'hBFFFF;
    localparam logic [19:0] ROM_LO = 20'hC0000;
    localparam logic [19:0] ROM_HI = 20'hC7FFF;
    localparam logic [19:0] ROM_XLO = 20'hC6000;
    localparam logic [19:0] ROM_XHI = 20'hC67FF;
    localparam logic [15:0] PAL_LO = 16'h03C6;
    localparam logic [15:0] PAL_HI = 16'h03C9;
    localparam logic [15:0] PAL_NORD = 16'h03C7;
    localparam logic [15:0] SETUP_PORT = 16'h0102;
    localparam logic [15:0] ROM_PAGE_PORT = 16'h46E8;
    localparam logic [15:0] VGA_IO_LO = 16'h03B0;
    localparam logic [15:0] VGA_IO_HI = 16'h03DF;
    localparam int CFG_CHAN_BIT = 2;
    localparam int EXT1_ROM_EN_BIT = 0;
    localparam int CLK_PER_TP = 1;
    localparam int IO_RD_DLY_TP = 2;
    localparam int IO_WR_DLY_TP = 3;
    localparam logic [1:0] IO_RD_DLY = 2'(IO_RD_DLY_TP * CLK_PER_TP);
    localparam logic [1:0] IO_WR_DLY = 2'(IO_WR_DLY_TP * CLK_PER_TP);
    localparam logic DIR_RST = 1'b0;
    // every synchronised line idles high, so a reset pipe shows no strobe
    localparam logic SYNC_RST = 1'b1;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR_OFF, ST_ACTIVE, ST_DATA_OFF
    } dmhbi_state_t;
    typedef struct packed {
        logic [19:0] addr;
        logic mem_space;
        logic bhe_n;
        logic mrd_n;
        logic mwr_n;
        logic ior_n;
        logic iow_n;
        logic cmd_n;
        logic s0_n;
        logic s1_n;
        logic mem_io;
        logic ion_n;
    } dmhbi_pins_t;
endpackage : dmhbi_pkg

// [rtl/dmhbi_sync.sv]
// multi stage synchroniser on the clock it is given
`timescale 1ns/1ps
`default_nettype none
module dmhbi_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic reset,
    dmhbi_sync_if.syncer port
);
    import dmhbi_pkg::*;
    localparam int W = $bits(port.raw);
    typedef struct packed {
        logic [STAGES-1:0][W-1:0] pipe;
    } dmhbi_sync_st_t;
    dmhbi_sync_st_t q, d;
    if (STAGES < 2) begin : g_chk
        $error("dmhbi_sync needs at least two stages");
    end
    // only the last stage is read outside
    always_comb begin
        d = q;
        d.pipe = {q.pipe[STAGES-2:0], port.raw};
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            q <= {$bits(q){SYNC_RST}};
        end else begin
            q <= d;
        end
    end
    assign port.synced = q.pipe[STAGES-1];
endmodule : dmhbi_sync
`default_nettype wire

// [rtl/dmhbi_sync_if.sv]
// carrier between the block and its synchronisers
`timescale 1ns/1ps
`default_nettype none
interface dmhbi_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport user (output raw, input synced);
    modport syncer (input raw, output synced);
endinterface : dmhbi_sync_if
`default_nettype wire

// [testbench/dmhbi_host_bus_test.sv]
// self-checking bench for the dual mode host bus interface
`timescale 1ns/1ps
`default_nettype none
module dmhbi_host_bus_test;
    import dmhbi_pkg::*;
    logic clk, video_clk, reset, memory_ack;
    logic [7:0] cfg, ext1;
    logic memory_request, rom_select_n, palette_read_strobe_n;
    logic palette_write_strobe_n, select_feedback_n, buffer_direction;
    logic wide_transfer_response_n, addr_buffer_enable_n;
    logic data_buffer_enable_n, ready_out, ready_oe;
    dmhbi_pins_t pins;
    wire logic ready_pin = ready_oe ? ready_out : 1'b1;
    logic [31:0] lfsr = 32'hCA28;
    logic [6:0] seen;
    logic mreq_seen;
    int cyc = 0, t0 = 0, rd_at, error_cnt = 0, n_checks = 0;
    int lat[2];
    logic [19:0] mem_tab[10] = '{20'hC0000, 20'hC7FFF, 20'hC6000,
        20'hC67FF, 20'hC5FFF, 20'hC6800, 20'hBFFFF, 20'hA0000,
        20'h9FFFF, 20'hC8000};

    dmhbi_host_bus dut_u (
        .clk, .reset, .video_clk,
        .config_register(cfg),
        .extended_control_1(ext1),
        .host_addr(pins.addr),
        .memory_space_select(pins.mem_space),
        .high_byte_enable_n(pins.bhe_n),
        .memory_read_strobe_n(pins.mrd_n),
        .memory_write_strobe_n(pins.mwr_n),
        .io_read_strobe_n(pins.ior_n),
        .io_write_strobe_n(pins.iow_n),
        .command_n(pins.cmd_n),
        .status_write_n(pins.s0_n),
        .status_read_n(pins.s1_n),
        .mem_not_io(pins.mem_io),
        .io_enable_card_setup_n(pins.ion_n),
        .memory_ack, .memory_request, .rom_select_n,
        .palette_read_strobe_n, .palette_write_strobe_n,
        .select_feedback_n, .wide_transfer_response_n,
        .addr_buffer_enable_n, .data_buffer_enable_n,
        .buffer_direction, .ready_out, .ready_oe
    );
    dmhbi_host_model host_u (.clk, .ready_pin, .pins);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // pixel clock unrelated in rate and phase to the memory clock
    initial begin
        video_clk = 1'b0;
        #7;
        forever #18.5 video_clk = ~video_clk;
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time,
                     got, exp);
        end
    endtask : check

    task automatic stop_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // video memory arbiter: grants after a random wait
    initial begin
        memory_ack = 1'b0;
        forever begin
            @(posedge clk);
            if (memory_request === 1'b1 && memory_ack === 1'b0) begin
                repeat (lfsr[2:0]) @(posedge clk);
                memory_ack <= 1'b1;
                @(posedge clk);
                memory_ack <= 1'b0;
            end
        end
    end

    // gathers which outputs went active during one host access
    always @(posedge clk) begin
        cyc <= cyc + 1;
        seen = seen | {buffer_direction, ready_oe & ~ready_out,
            ~wide_transfer_response_n, ~select_feedback_n,
            ~palette_write_strobe_n, ~palette_read_strobe_n, ~rom_select_n};
        mreq_seen = mreq_seen | memory_request;
        if (palette_read_strobe_n === 1'b0 && rd_at < 0) rd_at = cyc - t0;
        // both buffers on at once would short the shared lines
        if (!reset && addr_buffer_enable_n === 1'b0
            && data_buffer_enable_n === 1'b0) check(32'h1, 32'h0);
        if (cyc == 10000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic access(input int k, input bit ch, input logic [19:0] a,
                          input logic bhe, input logic cs_n);
        logic [6:0] e, m;
        logic [15:0] p;
        bit rom, vid, hit;
        @(posedge clk);
        cfg[CFG_CHAN_BIT] <= ch;
        @(negedge clk);
        seen = '0;
        mreq_seen = 1'b0;
        rd_at = -1;
        t0 = cyc;
        host_u.run(k, ch, a, bhe, cs_n);
        @(negedge clk);
        p = a[15:0];
        rom = ext1[EXT1_ROM_EN_BIT] && a >= ROM_LO && a <= ROM_HI
              && !(a >= ROM_XLO && a <= ROM_XHI);
        vid = a >= VMEM_LO && a <= VMEM_HI;
        hit = k < 2 ? vid || rom : (p >= VGA_IO_LO && p <= VGA_IO_HI)
              || p == SETUP_PORT || p == ROM_PAGE_PORT;
        e[0] = (k == 0 && rom) || (!ch && k == 3 && p == ROM_PAGE_PORT);
        e[1] = k == 2 && p >= PAL_LO && p <= PAL_HI && p != PAL_NORD;
        e[2] = k == 3 && p >= PAL_LO && p <= PAL_HI;
        e[3] = ch && hit && !(k > 1 && p == SETUP_PORT && !cs_n);
        e[4] = k < 2 && hit && !bhe;
        e[5] = k < 2 && hit;
        e[6] = k % 2 == 0;
        m = 7'h7F;
        // select feedback, wide response and pacing of rom window addresses without rom select are left open
        if (k < 2 && a >= ROM_LO && a <= ROM_HI && !rom) m[5:3] = 3'h0;
        if (!hit) m[6] = 1'b0;
        check(32'(seen & m), 32'(e & m));
        check(32'(ready_oe), 32'h0);
        check(32'(mreq_seen), 32'(k < 2 && vid));
        check(32'(host_u.timeouts), 32'h0);
    endtask : access

    initial begin
        logic [19:0] a;
        logic [31:0] r;
        bit rw;
        int k;
        reset = 1'b1;
        cfg = 8'h00;
        ext1 = 8'h01;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check(32'(buffer_direction), 32'(DIR_RST));
        for (int ch = 0; ch < 2; ch++) begin
            for (int p = 32'h3C5; p <= 32'h3CA; p++) begin
                access(2, ch, 20'(p), 1'b1, 1'b1);
                if (p == 32'h3C8) lat[ch] = rd_at;
                access(3, ch, 20'(p), 1'b1, 1'b1);
            end
            foreach (mem_tab[i]) begin
                a = mem_tab[i];
                r = rnd();
                rw = a >= ROM_LO && a <= ROM_HI;
                access(0, ch, a, r[0], 1'b1);
                if (!rw) access(1, ch, a, r[1], 1'b1);
            end
        end
        check(32'(lat[1] - lat[0]), 32'(IO_RD_DLY));
        access(2, 1, 20'h00102, 1'b1, 1'b0);
        access(2, 1, 20'h00102, 1'b1, 1'b1);
        access(3, 1, 20'h003C8, 1'b1, 1'b0);
        access(3, 0, 20'h046E8, 1'b1, 1'b1);
        access(3, 1, 20'h046E8, 1'b1, 1'b1);
        access(2, 1, 20'h00300, 1'b1, 1'b1);
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            k = 32'(r[1:0]);
            a = k < 2 ? {2'b10, r[25:8]} : {8'h00, 8'h3C, r[11:8]};
            access(k, r[12], a, r[13], r[14]);
        end
        @(posedge clk);
        ext1 <= 8'h00;
        access(0, 0, 20'hC0000, 1'b1, 1'b1);
        access(0, 1, 20'hC4000, 1'b1, 1'b1);
        stop_test();
    end
endmodule : dmhbi_host_bus_test
`default_nettype wire

// [testbench/dmhbi_host_model.sv]
// host side bus master model driving the block's host pins
`timescale 1ns/1ps
`default_nettype none
module dmhbi_host_model (
    input wire logic clk,
    input wire logic ready_pin,
    output var dmhbi_pkg::dmhbi_pins_t pins
);
    import dmhbi_pkg::*;
    // accesses whose ready never came back high
    int timeouts = 0;
    initial pins = '1;
    // kind: 0 memory read, 1 memory write, 2 io read, 3 io write
    task automatic run(input int kind, input bit chan, input logic [19:0] a,
                       input logic bhe_n, input logic setup_n);
        dmhbi_pins_t p;
        int n;
        p = pins;
        // address, space and card setup lead the strobe by a cycle
        p.addr = a;
        p.mem_space = 1'b1;
        p.bhe_n = bhe_n;
        p.mem_io = kind < 2;
        p.ion_n = setup_n;
        p.s1_n = !(chan && kind % 2 == 0);
        p.s0_n = !(chan && kind % 2 == 1);
        @(posedge clk);
        pins <= p;
        p.cmd_n = !chan;
        p.mrd_n = !(!chan && kind == 0);
        p.mwr_n = !(!chan && kind == 1);
        p.ior_n = !(!chan && kind == 2);
        p.iow_n = !(!chan && kind == 3);
        @(posedge clk);
        pins <= p;
        // status drops soon after the command, the rest stays latched
        p.s1_n = 1'b1;
        p.s0_n = 1'b1;
        @(posedge clk);
        pins <= p;
        repeat (5) @(posedge clk);
        n = 0;
        // a slow device holds us here until the pulled-up ready is high
        while (ready_pin !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) timeouts++;
        p.cmd_n = 1'b1;
        p.mrd_n = 1'b1;
        p.mwr_n = 1'b1;
        p.ior_n = 1'b1;
        p.iow_n = 1'b1;
        pins <= p;
        @(posedge clk);
        // released lines show the inverse of their last level
        p.addr = ~a;
        p.mem_space = 1'b0;
        p.bhe_n = ~bhe_n;
        p.mem_io = ~p.mem_io;
        p.ion_n = ~setup_n;
        pins <= p;
        repeat (6) @(posedge clk);
    endtask : run
endmodule : dmhbi_host_model
`default_nettype wire
